// ### hcl_defines.svh
// Constants of the hiccup limit and configuration latch block.
// Assumes inclusion by bare name from files that need offsets or counts.
`ifndef HCL_DEFINES_SVH
`define HCL_DEFINES_SVH
// Register byte offsets
`define HCL_OFS_CTRL 5'h00
`define HCL_OFS_STAT 5'h04
`define HCL_OFS_CFG 5'h08
`define HCL_OFS_CNT 5'h0c
`define HCL_OFS_OFF 5'h10
// Control fields
`define HCL_CTRL_SYNC 0
`define HCL_CTRL_HOLD 1
`define HCL_CTRL_RST 2'h0
// Feedback strap codes
`define HCL_FB_SHORT 2'h0
`define HCL_FB_R24K9 2'h1
`define HCL_FB_R49K9 2'h2
`define HCL_FB_DIV 2'h3
// Mode strap codes
`define HCL_MD_SA 3'h0
`define HCL_MD_SA_SS 3'h1
`define HCL_MD_PRI 3'h2
`define HCL_MD_PRI_SS 3'h3
`define HCL_MD_SEC 3'h4
// Timing
`define HCL_MCLK_NS 50
`define HCL_SS_TIME_NS 2800000
`define HCL_HIC_LAST 9'h1ff
`define HCL_CLEAN_LAST 2'h3
`define HCL_OCP_EVENTS 5'h10
`define HCL_OFF_LAST 14'h3fff
`endif

// ### hcl_pkg.sv
// Types shared by the hiccup limit and configuration latch block.
// Assumes nothing beyond a SystemVerilog compiler.
package hcl_pkg;
    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_LATCH = 5'h02,
        ST_SOFT = 5'h04,
        ST_RUN = 5'h08,
        ST_HIC = 5'h10
    } hcl_state_t;
    typedef enum logic [1:0] {
        ROLE_ALONE = 2'h0,
        ROLE_PRI = 2'h1,
        ROLE_SEC = 2'h2
    } hcl_role_t;
    // Latched configuration as seen by the analog side
    typedef struct packed {
        logic [1:0] vout_sel;
        logic bias_8v;
        logic int_comp;
        hcl_role_t role;
        logic ss_mod;
    } hcl_cfg_t;
endpackage

// ### hcl_sync2.sv
// Two-flop synchroniser bank for the asynchronous analog flags.
// Assumes inputs change without regard to mclk.
`timescale 1ns/10ps
module hcl_sync2 import hcl_pkg::*; #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    // One pair of flops per bit; first stage read only by the second
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    meta_r[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    meta_r[i] <= d[i];
                    q[i] <= meta_r[i];
                end
            end
        end
    endgenerate
endmodule

// ### hcl_strap_hold.sv
// Holds one strap code from a single capture until cleared.
// Assumes the code input is already synchronised to mclk.
`timescale 1ns/10ps
module hcl_strap_hold import hcl_pkg::*; #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Control
    input wire logic clr,
    input wire logic cap,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic held
);
    // Only the first capture after a clear counts
    always_ff @(posedge mclk) begin
        if (sys_rst || clr) begin
            q <= '0;
            held <= 1'b0;
        end else if (cap && !held) begin
            q <= d;
            held <= 1'b1;
        end
    end
endmodule

// ### hcl_core.sv
// Supervision core: strap latching, sequencing and overcurrent hiccup.
// Assumes analog comparators and strap detectors arrive asynchronously
// and an Avalon-MM master on mclk reaches the registers.
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "hcl_defines.svh"

module hcl_core import hcl_pkg::*; #(
    parameter int SS_CYC = `HCL_SS_TIME_NS / `HCL_MCLK_NS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Analog flags and strap detector codes
    input wire logic en_pin,
    input wire logic vcc_ok,
    input wire logic osc_clk,
    input wire logic shunt_sense_plus_trip,
    input wire logic feedback_pin_above_400mv,
    input wire logic ton_below_min,
    input wire logic pgood_raw,
    input wire logic [1:0] feedback_pin_code,
    input wire logic compensation_node_pin_100k,
    input wire logic [2:0] mode_code,
    // Drive and supervision outputs
    output hcl_cfg_t cfg,
    output logic hs_drive_en,
    output logic ls_drive_en,
    output logic hs_pulse_kill,
    output logic pulse_skip,
    output logic ss_pull_low,
    output logic ss_clamp_en,
    output logic ext_sync_en,
    output logic ea_oe_n,
    output logic power_good_output,
    output logic power_good_output_oe_n
);
    hcl_state_t state_r, state_nxt;
    logic [12:0] s_in, s_q;
    logic en_s, vcc_s, osc_s, cs_s, fb4_s, ton_s, pg_s;
    logic [1:0] fb_code_s;
    logic comp_s;
    logic [2:0] md_code_s;
    logic osc_d_r, tick, trip_cyc_r, trip_now;
    logic [16:0] ss_cnt_r;
    logic [8:0] hic_cnt_r;
    logic [1:0] clean_cnt_r;
    logic [4:0] ocp_cnt_r;
    logic [13:0] off_cnt_r;
    logic fb_ok_r, hic_act, hic_full, hic_trip;
    logic [1:0] ctrl_r;
    logic run_en, cap;
    logic [1:0] fb_q, md_role_q;
    logic [2:0] md_q;
    logic comp_q, fb_held, md_held;
    hcl_cfg_t cfg_nxt;
    logic req, acc, wr_ctrl;
    logic [31:0] rd_nxt;

    // Every analog flag and strap code crosses here first
    assign s_in = {mode_code, compensation_node_pin_100k, feedback_pin_code,
                   pgood_raw, ton_below_min, feedback_pin_above_400mv,
                   shunt_sense_plus_trip, osc_clk, vcc_ok, en_pin};
    hcl_sync2 #(.W(13)) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .d(s_in),
        .q(s_q)
    );
    assign {md_code_s, comp_s, fb_code_s, pg_s, ton_s, fb4_s, cs_s, osc_s,
            vcc_s, en_s} = s_q;

    // Feedback strap decode: all four codes are legal
    function automatic logic [2:0] fb_decode(input logic [1:0] c);
        unique case (c)
            `HCL_FB_SHORT: fb_decode = {`HCL_FB_SHORT, 1'b0};
            `HCL_FB_R24K9: fb_decode = {`HCL_FB_R24K9, 1'b0};
            `HCL_FB_R49K9: fb_decode = {`HCL_FB_R49K9, 1'b1};
            default: fb_decode = {`HCL_FB_DIV, 1'b1};
        endcase
    endfunction

    // Mode strap decode; unknown codes fall to standalone, no spreading
    function automatic logic [2:0] md_decode(input logic [2:0] c);
        unique case (c)
            `HCL_MD_SA_SS: md_decode = {ROLE_ALONE, 1'b1};
            `HCL_MD_PRI: md_decode = {ROLE_PRI, 1'b0};
            `HCL_MD_PRI_SS: md_decode = {ROLE_PRI, 1'b1};
            `HCL_MD_SEC: md_decode = {ROLE_SEC, 1'b0};
            default: md_decode = {ROLE_ALONE, 1'b0};
        endcase
    endfunction

    // Software hold acts like enable low, so it also relatches the mode
    assign run_en = en_s && vcc_s && !ctrl_r[`HCL_CTRL_HOLD];
    assign cap = (state_r == ST_LATCH);

    // Feedback strap clears only with supply reset
    hcl_strap_hold #(.W(2)) u_fb_hold (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clr(1'b0),
        .cap(cap),
        .d(fb_code_s),
        .q(fb_q),
        .held(fb_held)
    );
    // Compensation clears only once the bias rail has collapsed
    hcl_strap_hold #(.W(1)) u_comp_hold (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clr(!vcc_s),
        .cap(cap),
        .d(comp_s),
        .q(comp_q),
        .held()
    );
    // Mode strap relatches after an enable toggle
    hcl_strap_hold #(.W(3)) u_md_hold (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clr(state_r == ST_OFF),
        .cap(cap),
        .d(md_code_s),
        .q(md_q),
        .held(md_held)
    );

    // Configuration seen by the power stage
    assign {cfg_nxt.vout_sel, cfg_nxt.bias_8v} = fb_decode(fb_q);
    assign cfg_nxt.int_comp = comp_q;
    assign {md_role_q, cfg_nxt.ss_mod} = md_decode(md_q);
    assign cfg_nxt.role = hcl_role_t'(md_role_q);

    // One tick per switching-oscillator rising edge
    assign tick = osc_s && !osc_d_r;
    assign trip_now = trip_cyc_r || cs_s;

    // Hiccup watches only after soft-start and feedback above 0.4 V
    assign hic_act = (state_r == ST_RUN) && fb_ok_r;
    assign hic_trip = hic_act && tick && trip_now;
    assign hic_full = hic_trip && (hic_cnt_r == `HCL_HIC_LAST);

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_OFF: if (run_en) state_nxt = ST_LATCH;
            ST_LATCH: state_nxt = ST_SOFT;
            ST_SOFT: if (ss_cnt_r == 17'(SS_CYC - 1)) state_nxt = ST_RUN;
            ST_RUN: if (hic_full && !fb4_s) state_nxt = ST_HIC;
            ST_HIC: if (tick && off_cnt_r == `HCL_OFF_LAST) begin
                state_nxt = ST_SOFT;
            end
            default: state_nxt = ST_OFF;
        endcase
        if (!run_en) state_nxt = ST_OFF;
    end

    // State and soft-start timer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_r <= ST_OFF;
            ss_cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            ss_cnt_r <= (state_r == ST_SOFT) ? ss_cnt_r + 17'h1 : '0;
        end
    end

    // Trip kept up to its closing tick; carrying it past would count it twice
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            osc_d_r <= 1'b0;
            trip_cyc_r <= 1'b0;
        end else begin
            osc_d_r <= osc_s;
            trip_cyc_r <= !tick && (cs_s || trip_cyc_r);
        end
    end

    // Feedback-good flag rearms at every soft-start
    always_ff @(posedge mclk) begin
        if (sys_rst || state_r != ST_RUN) fb_ok_r <= 1'b0;
        else if (fb4_s) fb_ok_r <= 1'b1;
    end

    // Hiccup and clean-cycle counters
    always_ff @(posedge mclk) begin
        if (sys_rst || !hic_act) begin
            hic_cnt_r <= '0;
            clean_cnt_r <= '0;
        end else if (tick && trip_now) begin
            hic_cnt_r <= hic_cnt_r + 9'h1; // wraps to zero
            clean_cnt_r <= '0;
        end else if (tick) begin
            clean_cnt_r <= clean_cnt_r + 2'h1;
            if (clean_cnt_r == `HCL_CLEAN_LAST) hic_cnt_r <= '0;
        end
    end

    // Overcurrent events saturate at the clamp threshold
    always_ff @(posedge mclk) begin
        if (sys_rst || state_r == ST_OFF) ocp_cnt_r <= '0;
        else if (tick && trip_now && ocp_cnt_r != `HCL_OCP_EVENTS) begin
            ocp_cnt_r <= ocp_cnt_r + 5'h1;
        end
    end

    // Off timer runs only while stopped
    always_ff @(posedge mclk) begin
        if (sys_rst || state_r != ST_HIC) off_cnt_r <= '0;
        else if (tick) off_cnt_r <= off_cnt_r + 14'h1;
    end

    // Drive and supervision outputs, all registered
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg <= '0;
            hs_drive_en <= 1'b0;
            ls_drive_en <= 1'b0;
            hs_pulse_kill <= 1'b0;
            pulse_skip <= 1'b0;
            ss_pull_low <= 1'b1;
            ss_clamp_en <= 1'b0;
            ext_sync_en <= 1'b0;
            ea_oe_n <= 1'b1;
            power_good_output <= 1'b0;
            power_good_output_oe_n <= 1'b0;
        end else begin
            cfg <= cfg_nxt;
            hs_drive_en <= (state_nxt == ST_SOFT) || (state_nxt == ST_RUN);
            ls_drive_en <= (state_nxt == ST_SOFT) || (state_nxt == ST_RUN);
            hs_pulse_kill <= cs_s;
            pulse_skip <= ton_s;
            ss_pull_low <= !((state_nxt == ST_SOFT) || (state_nxt == ST_RUN));
            ss_clamp_en <= (ocp_cnt_r == `HCL_OCP_EVENTS) && cs_s;
            ext_sync_en <= ctrl_r[`HCL_CTRL_SYNC] && !cfg_nxt.ss_mod && !cfg.ss_mod;
            ea_oe_n <= (cfg_nxt.role == ROLE_SEC) || !md_held;
            // Primary: pushes the inverted oscillator, three mclk after osc_clk
            if (cfg_nxt.role == ROLE_PRI) begin
                power_good_output <= !osc_s;
                power_good_output_oe_n <= 1'b0;
            end else begin
                power_good_output <= 1'b0;
                power_good_output_oe_n <= pg_s && (state_r == ST_RUN);
            end
        end
    end

    // Avalon slave: one wait cycle, then the answer
    assign req = read || write;
    assign acc = req && !waitrequest;
    assign wr_ctrl = acc && write && address == `HCL_OFS_CTRL && byteenable[0];

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_nxt = '0;
        unique case (address)
            `HCL_OFS_CTRL: rd_nxt[1:0] = ctrl_r;
            `HCL_OFS_STAT: rd_nxt[10:0] = {ss_clamp_en, fb_ok_r, ss_pull_low,
                                           hs_drive_en, fb_held, md_held,
                                           state_r};
            `HCL_OFS_CFG: rd_nxt[6:0] = cfg;
            `HCL_OFS_CNT: rd_nxt[15:0] = {ocp_cnt_r, clean_cnt_r, hic_cnt_r};
            `HCL_OFS_OFF: rd_nxt[13:0] = off_cnt_r;
            default: rd_nxt = '0;
        endcase
    end

    // Bus handshake and control register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            waitrequest <= 1'b1;
            readdata <= '0;
            ctrl_r <= `HCL_CTRL_RST;
        end else begin
            waitrequest <= !(req && waitrequest);
            if (req && waitrequest) readdata <= read ? rd_nxt : '0;
            if (wr_ctrl) ctrl_r <= writedata[1:0];
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    fb_strap_hold_a: assert property (
        fb_held && $changed(fb_code_s) |=> $stable(fb_q))
        else $error("feedback strap changed after latch");
    comp_default_a: assert property (
        cap && !comp_s && !u_comp_hold.held |-> ##2 !cfg.int_comp)
        else $error("internal compensation without strap");
    comp_clear_a: assert property (
        vcc_s && $past(vcc_s) && $past(comp_q) |-> comp_q)
        else $error("compensation lost with bias up");
    trip_kill_a: assert property (
        cs_s |=> hs_pulse_kill)
        else $error("current trip did not kill pulse");
    clamp_gate_a: assert property (
        ss_clamp_en |-> $past(ocp_cnt_r) == `HCL_OCP_EVENTS)
        else $error("clamp before sixteen events");
    hiccup_idle_a: assert property (
        state_r == ST_SOFT |-> hic_cnt_r == 9'h0)
        else $error("hiccup counting during soft-start");
    clean_clear_a: assert property (
        hic_act && tick && !trip_now && clean_cnt_r == `HCL_CLEAN_LAST
        ##0 hic_act |=> hic_cnt_r == 9'h0)
        else $error("four clean cycles kept count");
    full_high_a: assert property (
        hic_full && fb4_s && run_en |=> state_r == ST_RUN && hic_cnt_r == 9'h0)
        else $error("hiccup stopped with feedback high");
    full_low_a: assert property (
        hic_full && !fb4_s && run_en |=> state_r == ST_HIC ##1 ss_pull_low
        && !hs_drive_en && !ls_drive_en)
        else $error("hiccup did not stop drivers");
    off_end_a: assert property (
        state_r == ST_HIC && tick && off_cnt_r == `HCL_OFF_LAST && run_en
        |=> state_r == ST_SOFT)
        else $error("off timer did not restart");
    sync_block_a: assert property (
        cfg.ss_mod |=> !ext_sync_en)
        else $error("external sync with spreading on");
    sec_tristate_a: assert property (
        cfg.role == ROLE_SEC |=> ea_oe_n)
        else $error("secondary drove error amplifier");
    pri_sync_a: assert property (
        cfg.role == ROLE_PRI && $past(cfg.role) == ROLE_PRI
        |-> power_good_output == !$past(osc_s))
        else $error("primary sync clock wrong");
    ss_len_a: assert property (
        state_r == ST_RUN && $past(state_r) == ST_SOFT
        |-> $past(ss_cnt_r) == 17'(SS_CYC - 1))
        else $error("soft-start length wrong");
    skip_a: assert property (
        ton_s |=> pulse_skip)
        else $error("no pulse skip on short on-time");
endmodule

// ### tb_top.sv
// Self-checking bench for the hiccup limit and configuration latch core.
// Assumes one mclk domain and a core answering each bus request after a wait.
`timescale 1ns/10ps
`include "hcl_defines.svh"
module tb_top import hcl_pkg::*;;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic en_pin = 1'b0;
    logic vcc_ok = 1'b1;
    logic osc_clk = 1'b0;
    logic trip = 1'b0;
    logic fb_hi = 1'b0;
    logic ton_short = 1'b0;
    logic pgood_raw = 1'b1;
    logic [1:0] fb_code = 2'h0;
    logic comp_100k = 1'b0;
    logic [2:0] mode_code = 3'h0;
    hcl_cfg_t cfg;
    logic hs_drive_en, ls_drive_en, hs_pulse_kill, pulse_skip, ss_pull_low;
    logic ss_clamp_en, ext_sync_en, ea_oe_n, power_good_output, power_good_output_oe_n;
    int errors = 0;
    int checks_done = 0;
    logic [31:0] rd;

    // Short soft-start keeps the run within budget
    hcl_core #(.SS_CYC(20)) i_hcl_core (
        .mclk(mclk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .en_pin(en_pin), .vcc_ok(vcc_ok), .osc_clk(osc_clk),
        .shunt_sense_plus_trip(trip), .feedback_pin_above_400mv(fb_hi),
        .ton_below_min(ton_short), .pgood_raw(pgood_raw), .feedback_pin_code(fb_code),
        .compensation_node_pin_100k(comp_100k), .mode_code(mode_code), .cfg(cfg),
        .hs_drive_en(hs_drive_en), .ls_drive_en(ls_drive_en),
        .hs_pulse_kill(hs_pulse_kill), .pulse_skip(pulse_skip), .ss_pull_low(ss_pull_low),
        .ss_clamp_en(ss_clamp_en), .ext_sync_en(ext_sync_en), .ea_oe_n(ea_oe_n),
        .power_good_output(power_good_output),
        .power_good_output_oe_n(power_good_output_oe_n)
    );

    // 20 MHz clock
    always #25 mclk = ~mclk;

    task automatic wrap_up;
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Request stays up until a rising edge at which waitrequest is seen low
    task automatic wait_ack;
        int n;
        n = 0;
        @(posedge mclk);
        while (waitrequest !== 1'b0) begin
            if (n >= 50) begin
                errors++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, waitrequest, 1'b0);
                wrap_up();
            end
            n++;
            @(posedge mclk);
        end
    endtask

    task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge mclk);
        address <= a;
        read <= 1'b1;
        wait_ack();
        d = readdata;
        read <= 1'b0;
    endtask

    task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        wait_ack();
        write <= 1'b0;
    endtask

    // Poll the state field, bounded
    task automatic wait_state(input logic [4:0] st);
        int n;
        logic [31:0] s;
        for (n = 0; n < 400; n++) begin
            bus_rd(`HCL_OFS_STAT, s);
            if (s[4:0] === st) begin
                return;
            end
        end
        errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, s[4:0], st);
        wrap_up();
    endtask

    // One switching cycle of four mclk, caller at a rising edge; the trip
    // pulse ends on its own tick so it never spills into the next cycle
    task automatic tick(input logic t);
        trip <= t;
        @(posedge mclk);
        osc_clk <= 1'b1;
        @(posedge mclk);
        trip <= 1'b0;
        @(posedge mclk);
        osc_clk <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic power_up(input logic [1:0] f, input logic c, input logic [2:0] m);
        @(posedge mclk);
        sys_rst <= 1'b1;
        en_pin <= 1'b0;
        fb_code <= f;
        comp_100k <= c;
        mode_code <= m;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        en_pin <= 1'b1;
        wait_state(5'h08);
    endtask

    function automatic logic [31:0] exp_cfg(input logic [1:0] f, input logic c,
                                            input logic [2:0] m);
        logic [1:0] r;
        logic s;
        r = (m == 3'h2 || m == 3'h3) ? 2'h1 : (m == 3'h4) ? 2'h2 : 2'h0;
        s = (m == 3'h1 || m == 3'h3);
        return {25'h0, f, f[1], c, r, s};
    endfunction

    // Hang guard, counted as a mismatch
    initial begin
        repeat (95000) @(posedge mclk);
        errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        wrap_up();
    end

    initial begin
        int i;
        // Outputs while reset is held
        repeat (4) @(posedge mclk);
        chk(32'(waitrequest), 32'h1);
        chk(32'(ss_pull_low), 32'h1);
        chk(32'(ea_oe_n), 32'h1);
        // Every strap code, unknown mode codes included
        for (i = 0; i < 8; i++) begin // standalone, primary, secondary and unknown mode straps in turn
            power_up(i[1:0], i[0], i[2:0]);
            chk(32'(cfg), exp_cfg(i[1:0], i[0], i[2:0]));
            bus_rd(`HCL_OFS_CFG, rd);
            chk(rd, exp_cfg(i[1:0], i[0], i[2:0]));
            chk(32'(ea_oe_n), 32'(i == 4));
            bus_wr(`HCL_OFS_CTRL, 32'h1);
            repeat (4) @(posedge mclk);
            chk(32'(ext_sync_en), 32'(!(i == 1 || i == 3)));
            if (i == 2 || i == 3) begin
                chk(32'(power_good_output_oe_n), 32'h0);
                chk(32'(power_good_output), 32'h1);
            end else begin
                chk(32'(power_good_output_oe_n), 32'h1);
            end
        end
        // Strap changes after the latch are ignored
        fb_code <= 2'h0;
        comp_100k <= 1'b0;
        mode_code <= 3'h4;
        repeat (6) @(posedge mclk);
        chk(32'(cfg), exp_cfg(2'h3, 1'b1, 3'h7));
        // Enable toggle relatches mode only
        en_pin <= 1'b0;
        wait_state(5'h01);
        en_pin <= 1'b1;
        wait_state(5'h08);
        chk(32'(cfg), exp_cfg(2'h3, 1'b1, 3'h4));
        // Bias rail drop frees the compensation choice
        vcc_ok <= 1'b0;
        wait_state(5'h01);
        vcc_ok <= 1'b1;
        wait_state(5'h08);
        chk(32'(cfg), exp_cfg(2'h3, 1'b0, 3'h4));
        // Overcurrent sequence in standalone mode
        power_up(2'h1, 1'b0, 3'h0);
        ton_short <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(32'(pulse_skip), 32'h1);
        ton_short <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(32'(pulse_skip), 32'h0);
        // Feedback not yet seen high: trips do not reach the hiccup count
        repeat (3) tick(1'b1);
        chk(32'(hs_pulse_kill), 32'h1);
        chk(32'(ss_clamp_en), 32'h0);
        bus_rd(`HCL_OFS_CNT, rd);
        chk(32'(rd[8:0]), 32'h0);
        repeat (13) tick(1'b1);
        chk(32'(ss_clamp_en), 32'h0);
        tick(1'b1);
        chk(32'(ss_clamp_en), 32'h1);
        bus_rd(`HCL_OFS_CNT, rd);
        chk(32'(rd[15:11]), 32'h10);
        // Three trips survive three clean cycles, the fourth clears
        fb_hi <= 1'b1;
        tick(1'b0);
        repeat (3) tick(1'b1);
        bus_rd(`HCL_OFS_CNT, rd);
        chk(32'(rd[8:0]), 32'h3);
        repeat (3) tick(1'b0);
        bus_rd(`HCL_OFS_CNT, rd);
        chk(32'(rd[8:0]), 32'h3);
        tick(1'b0);
        bus_rd(`HCL_OFS_CNT, rd);
        chk(32'(rd[8:0]), 32'h0);
        // Full count with feedback high keeps switching
        repeat (512) tick(1'b1);
        bus_rd(`HCL_OFS_STAT, rd);
        chk(32'(rd[4:0]), 32'h08);
        bus_rd(`HCL_OFS_CNT, rd);
        chk(32'(rd[8:0]), 32'h0);
        // Full count with feedback low stops switching
        fb_hi <= 1'b0;
        repeat (512) tick(1'b1);
        repeat (4) @(posedge mclk);
        chk(32'(hs_drive_en), 32'h0);
        chk(32'(ls_drive_en), 32'h0);
        chk(32'(ss_pull_low), 32'h1);
        bus_rd(`HCL_OFS_STAT, rd);
        chk(32'(rd[4:0]), 32'h10);
        // Off timer runs its full length before restart, end points included
        repeat (16383) tick(1'b0);
        bus_rd(`HCL_OFS_OFF, rd);
        chk(32'(rd[13:0]), 32'h3fff);
        bus_rd(`HCL_OFS_STAT, rd);
        chk(32'(rd[4:0]), 32'h10);
        tick(1'b0);
        bus_rd(`HCL_OFS_STAT, rd);
        chk(32'(rd[4:0]), 32'h04);
        chk(32'(hs_drive_en), 32'h1);
        chk(32'(ss_pull_low), 32'h0);
        wrap_up();
    end
endmodule
